/* logic/async_serial_port_controller.v */
// Purpose: byte-wide serial port controller behind host I/O ports
// Assumes: host strobes are one-cycle and synchronous to clock
// Notes: no receive fifo; one holding and one shift register per way
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_consts.vh"
module async_serial_port_controller (
	input  wire       clock,
	input  wire       rst_b,
	input  wire [9:0] port_addr,
	input  wire       port_rd,
	input  wire       port_wr,
	input  wire [7:0] port_wdata,
	output reg  [7:0] port_rdata_r,
	output reg        intr_r,
	output reg        tx_out_r,
	input  wire       rx_in,
	output reg        dtr_r,
	output reg        rts_r,
	output reg        out1_r,
	output reg        out2_r,
	input  wire       cts_in,
	input  wire       dsr_in,
	input  wire       ri_in,
	input  wire       dcd_in
);
	localparam TX_IDLE  = 4'b0001;
	localparam TX_START = 4'b0010;
	localparam TX_DATA  = 4'b0100;
	localparam TX_STOP  = 4'b1000;
	localparam RX_IDLE  = 4'b0001;
	localparam RX_START = 4'b0010;
	localparam RX_DATA  = 4'b0100;
	localparam RX_STOP  = 4'b1000;
	localparam [15:0] DIV_INIT = `DIV_RESET;

	reg  [7:0]  lcr_r, mcr_r, ier_r, dll_r, dlm_r;
	reg  [7:0]  thr_r, tsr_r, rbr_r;
	reg         tx_holding_empty_r, dr_r, oe_r, pe_r, fe_r, bi_r, tx_holding_empty_int_r;
	reg  [3:0]  msr_delta_r, msr_prev_r;
	reg  [3:0]  tx_state_r, rx_state_r;
	reg  [3:0]  tx_sub_r, rx_sub_r, tx_cnt_r, rx_cnt_r;
	reg         tx_par_r, tx_line_r;
	reg  [7:0]  rx_shift_r;
	reg         rx_par_r;
	wire        tick;
	wire [3:0]  nbits;
	wire [7:0]  tx_masked, rx_masked;
	wire        tx_podd, rx_podd;
	wire        divisor_access_bit = lcr_r[`LCR_DIVISOR_ACCESS_BIT];
	wire        loop = mcr_r[`MCR_LOOP];
	// modem inputs replaced by control outputs, receive input by transmit line, in loopback
	wire        rx_line = loop ? tx_line_r : rx_in;
	wire [3:0]  modem_in = loop ? {mcr_r[3], mcr_r[2], mcr_r[0], mcr_r[1]}
	                            : {dcd_in, ri_in, dsr_in, cts_in};
	wire        wr_data = port_wr && port_addr == `OFF_DATA && !divisor_access_bit;
	wire        rd_data = port_rd && port_addr == `OFF_DATA && !divisor_access_bit;
	wire        rd_lsr  = port_rd && port_addr == `OFF_LSR;
	wire        rd_msr  = port_rd && port_addr == `OFF_MSR;
	wire        rd_iir  = port_rd && port_addr == `OFF_IIR;
	wire        line_pend = ier_r[2] && (oe_r || pe_r || fe_r || bi_r);
	wire        rx_pend   = ier_r[0] && dr_r;
	wire        tx_pend   = ier_r[1] && tx_holding_empty_int_r;
	wire        ms_pend   = ier_r[3] && (msr_delta_r != 4'h0);
	wire [7:0]  lsr_val = {1'b0, tx_holding_empty_r && tx_state_r == TX_IDLE, tx_holding_empty_r,
	                       bi_r, fe_r, pe_r, oe_r, dr_r};
	reg  [7:0]  iir_val;
	always @* begin
		if (line_pend)
			iir_val = `IIR_LINE;
		else if (rx_pend)
			iir_val = `IIR_RXDATA;
		else if (tx_pend)
			iir_val = `IIR_TX_HOLDING_EMPTY;
		else if (ms_pend)
			iir_val = `IIR_MODEM;
		else
			iir_val = `IIR_NONE;
	end
	baud_tick_gen u_tick (
		.clock    (clock),
		.rst_b    (rst_b),
		.divisor  ({dlm_r, dll_r}),
		.tick16_r (tick)
	);
	// data width and parity per length code
	char_frame_bits u_txbits (
		.len_code   (lcr_r[1:0]),
		.data       (tsr_r),
		.nbits      (nbits),
		.masked     (tx_masked),
		.parity_odd (tx_podd)
	);
	char_frame_bits u_rxbits (
		.len_code   (lcr_r[1:0]),
		.data       (rx_shift_r),
		.nbits      (),
		.masked     (rx_masked),
		.parity_odd (rx_podd)
	);
	// parity bit value: stick forces constant
	function parity_bit;
		input [7:0] l;
		input       podd;
		begin
			if (l[`LCR_STICK])
				parity_bit = ~l[`LCR_EVEN];
			else
				parity_bit = l[`LCR_EVEN] ? podd : ~podd;
		end
	endfunction

	// host register writes
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			lcr_r <= `ZERO8;
			mcr_r <= `ZERO8;
			ier_r <= `ZERO8;
			dll_r <= DIV_INIT[7:0];
			dlm_r <= DIV_INIT[15:8];
		end else if (port_wr) begin
			if (port_addr == `OFF_DATA && divisor_access_bit)
				dll_r <= port_wdata;
			else if (port_addr == `OFF_IER && divisor_access_bit)
				dlm_r <= port_wdata;
			else if (port_addr == `OFF_IER)
				ier_r <= {4'h0, port_wdata[3:0]};
			else if (port_addr == `OFF_LCR)
				lcr_r <= port_wdata;
			else if (port_addr == `OFF_MCR)
				mcr_r <= {3'b000, port_wdata[4:0]};
		end
	end

	// transmitter
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			thr_r      <= `ZERO8;
			tsr_r      <= `ZERO8;
			tx_holding_empty_r     <= 1'b1;
			tx_holding_empty_int_r <= 1'b0;
			tx_state_r <= TX_IDLE;
			tx_sub_r   <= 4'h0;
			tx_cnt_r   <= 4'h0;
			tx_par_r   <= 1'b0;
			tx_line_r  <= 1'b1;
		end else begin
			if (wr_data) begin
				thr_r  <= port_wdata;
				tx_holding_empty_r <= 1'b0;
			end
			// set wins over the clear by ident read; a data write blocks the set and clears
			if (tx_state_r == TX_IDLE && !tx_holding_empty_r && !wr_data) begin
				tx_holding_empty_int_r <= 1'b1;
			end else if (wr_data || (rd_iir && !line_pend && !rx_pend))
				tx_holding_empty_int_r <= 1'b0;
			if (tick) begin
				case (tx_state_r)
				TX_IDLE: begin
					if (!tx_holding_empty_r) begin
						tsr_r      <= thr_r;
						tx_holding_empty_r     <= 1'b1;
						tx_state_r <= TX_START;
						tx_sub_r   <= 4'h0;
						tx_line_r  <= 1'b0;
					end
				end
				TX_START: begin
					tx_sub_r <= tx_sub_r + 4'h1;
					if (tx_sub_r == `OVERSAMPLE) begin
						tx_state_r <= TX_DATA;
						tx_cnt_r   <= 4'h0;
						tx_par_r   <= parity_bit(lcr_r, tx_podd);
						tx_line_r  <= tx_masked[0];
					end
				end
				TX_DATA: begin
					tx_sub_r <= tx_sub_r + 4'h1;
					if (tx_sub_r == `OVERSAMPLE) begin
						tx_cnt_r <= tx_cnt_r + 4'h1;
						if (tx_cnt_r + 4'h1 < nbits) begin
							tx_line_r <= tsr_r[tx_cnt_r[2:0] + 3'd1];
						end else if (tx_cnt_r + 4'h1 == nbits && lcr_r[`LCR_PEN]) begin
							tx_line_r <= tx_par_r;
						end else begin
							tx_state_r <= TX_STOP;
							tx_cnt_r   <= 4'h0;
							tx_line_r  <= 1'b1;
						end
					end
				end
				TX_STOP: begin
					tx_sub_r <= tx_sub_r + 4'h1;
					if (tx_sub_r == `OVERSAMPLE) begin
						tx_cnt_r <= tx_cnt_r + 4'h1;
						if (tx_cnt_r[0] || !lcr_r[`LCR_STOP2])
							tx_state_r <= TX_IDLE;
					end
				end
				default: tx_state_r <= TX_IDLE;
				endcase
			end
		end
	end

	// receiver, sampling at bit centre
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rbr_r      <= `ZERO8;
			rx_shift_r <= `ZERO8;
			rx_state_r <= RX_IDLE;
			rx_sub_r   <= 4'h0;
			rx_cnt_r   <= 4'h0;
			rx_par_r   <= 1'b0;
			dr_r       <= 1'b0;
			oe_r       <= 1'b0;
			pe_r       <= 1'b0;
			fe_r       <= 1'b0;
			bi_r       <= 1'b0;
		end else begin
			if (rd_data)
				dr_r <= 1'b0;
			if (rd_lsr) begin
				oe_r <= 1'b0;
				pe_r <= 1'b0;
				fe_r <= 1'b0;
				bi_r <= 1'b0;
			end
			if (tick) begin
				case (rx_state_r)
				RX_IDLE: begin
					if (!rx_line) begin
						rx_state_r <= RX_START;
						rx_sub_r   <= 4'h0;
					end
				end
				RX_START: begin
					rx_sub_r <= rx_sub_r + 4'h1;
					if (rx_sub_r == `OVERSAMPLE_MID) begin
						if (rx_line) begin
							rx_state_r <= RX_IDLE; // glitch, not a start bit
						end else begin
							rx_state_r <= RX_DATA;
							rx_sub_r   <= 4'h0;
							rx_cnt_r   <= 4'h0;
							rx_shift_r <= `ZERO8;
						end
					end
				end
				RX_DATA: begin
					rx_sub_r <= rx_sub_r + 4'h1;
					if (rx_sub_r == `OVERSAMPLE) begin
						rx_cnt_r <= rx_cnt_r + 4'h1;
						if (rx_cnt_r < nbits)
							rx_shift_r[rx_cnt_r[2:0]] <= rx_line;
						else if (rx_cnt_r == nbits && lcr_r[`LCR_PEN])
							rx_par_r <= rx_line;
						if (rx_cnt_r + 4'h1 == nbits + {3'b000, lcr_r[`LCR_PEN]})
							rx_state_r <= RX_STOP;
					end
				end
				RX_STOP: begin
					rx_sub_r <= rx_sub_r + 4'h1;
					if (rx_sub_r == `OVERSAMPLE) begin
						// only the first stop bit is checked
						rx_state_r <= RX_IDLE;
						rbr_r      <= rx_masked;
						dr_r       <= 1'b1;
						// error sets win over the status-read clear
						if (dr_r && !rd_data)
							oe_r <= 1'b1;
						if (lcr_r[`LCR_PEN] && rx_par_r != parity_bit(lcr_r, rx_podd))
							pe_r <= 1'b1;
						if (!rx_line)
							fe_r <= 1'b1;
						if (!rx_line && rx_masked == `ZERO8 && !rx_par_r)
							bi_r <= 1'b1;
					end
				end
				default: rx_state_r <= RX_IDLE;
				endcase
			end
		end
	end

	// modem status change detection
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			msr_prev_r  <= 4'h0;
			msr_delta_r <= 4'h0;
		end else begin
			msr_prev_r <= modem_in;
			// new changes survive a concurrent read
			msr_delta_r[0] <= (modem_in[0] ^ msr_prev_r[0]) | (msr_delta_r[0] & ~rd_msr);
			msr_delta_r[1] <= (modem_in[1] ^ msr_prev_r[1]) | (msr_delta_r[1] & ~rd_msr);
			msr_delta_r[2] <= (~modem_in[2] & msr_prev_r[2]) | (msr_delta_r[2] & ~rd_msr);
			msr_delta_r[3] <= (modem_in[3] ^ msr_prev_r[3]) | (msr_delta_r[3] & ~rd_msr);
		end
	end

	// read data, pins and interrupt, all registered
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			port_rdata_r <= `ZERO8;
			intr_r       <= 1'b0;
			tx_out_r     <= 1'b1;
			dtr_r        <= 1'b0;
			rts_r        <= 1'b0;
			out1_r       <= 1'b0;
			out2_r       <= 1'b0;
		end else begin
			intr_r <= line_pend || rx_pend || tx_pend || ms_pend;
			// break overrides; loopback holds pin idle
			tx_out_r <= loop ? 1'b1 : (tx_line_r && !lcr_r[`LCR_BREAK]);
			dtr_r    <= !loop && mcr_r[0];
			rts_r    <= !loop && mcr_r[1];
			out1_r   <= !loop && mcr_r[2];
			out2_r   <= !loop && mcr_r[3];
			if (port_rd) begin
				if (port_addr == `OFF_DATA)
					port_rdata_r <= divisor_access_bit ? dll_r : rbr_r;
				else if (port_addr == `OFF_IER)
					port_rdata_r <= divisor_access_bit ? dlm_r : ier_r;
				else if (port_addr == `OFF_IIR)
					port_rdata_r <= iir_val;
				else if (port_addr == `OFF_LCR)
					port_rdata_r <= lcr_r;
				else if (port_addr == `OFF_MCR)
					port_rdata_r <= mcr_r;
				else if (port_addr == `OFF_LSR)
					port_rdata_r <= lsr_val;
				else if (port_addr == `OFF_MSR)
					port_rdata_r <= {modem_in, msr_delta_r};
				else
					port_rdata_r <= `ZERO8;
			end
		end
	end
endmodule
`default_nettype wire

/* logic/baud_tick_gen.v */
// Purpose: sixteen-times baud enable from the divisor
// Assumes: divisor zero treated as one
// Notes: one-cycle pulse per oversample
`timescale 1ns/1ns
`default_nettype none
module baud_tick_gen (
	input  wire        clock,
	input  wire        rst_b,
	input  wire [15:0] divisor,
	output reg         tick16_r
);
	reg [15:0] count_r;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			count_r  <= 16'h0000;
			tick16_r <= 1'b0;
		end else if (count_r + 16'h0001 >= divisor) begin
			count_r  <= 16'h0000;
			tick16_r <= 1'b1;
		end else begin
			count_r  <= count_r + 16'h0001;
			tick16_r <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* logic/char_frame_bits.v */
// Purpose: bit count, parity helper for one character
// Assumes: length code from line control bits 1:0
// Notes: combinational, no state
`timescale 1ns/1ns
`default_nettype none
module char_frame_bits (
	input  wire [1:0] len_code,
	input  wire [7:0] data,
	output wire [3:0] nbits,
	output wire [7:0] masked,
	output wire       parity_odd
);
	assign nbits      = {2'b00, len_code} + 4'h5;
	assign masked     = data & (8'hff >> (2'd3 - len_code));
	assign parity_odd = ^masked;
endmodule
`default_nettype wire

/* logic/serial_port_consts.vh */
// Purpose: register offsets, fields and codes of the serial port controller
// Assumes: host port address is the full printed I/O address
// Notes: definitions only
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH
`define OFF_DATA        10'h03f8
`define OFF_IER         10'h03f9
`define OFF_IIR         10'h03fa
`define OFF_LCR         10'h03fb
`define OFF_MCR         10'h03fc
`define OFF_LSR         10'h03fd
`define OFF_MSR         10'h03fe
`define LCR_DIVISOR_ACCESS_BIT        7
`define LCR_BREAK       6
`define LCR_STICK       5
`define LCR_EVEN        4
`define LCR_PEN         3
`define LCR_STOP2       2
`define MCR_LOOP        4
`define IIR_LINE        8'h06
`define IIR_RXDATA      8'h04
`define IIR_TX_HOLDING_EMPTY        8'h02
`define IIR_MODEM       8'h00
`define IIR_NONE        8'h01
`define DIV_RESET       16'h000c
`define OVERSAMPLE      4'hf
`define OVERSAMPLE_MID  4'h7
`define ZERO8           8'h00
`endif

/* tb/port_checker_sva.sv */
// Purpose: port-level checks of the serial port controller
// Assumes: host strobes one cycle wide, registers mirrored from host writes
// Notes: mirrors avoid peeking into the design body
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_consts.vh"
module port_checker (
	input wire       clock,
	input wire       rst_b,
	input wire [9:0] port_addr,
	input wire       port_rd,
	input wire       port_wr,
	input wire [7:0] port_wdata,
	input wire [7:0] port_rdata_r,
	input wire       intr_r,
	input wire       tx_out_r,
	input wire       rx_in,
	input wire       dtr_r,
	input wire       rts_r,
	input wire       out1_r,
	input wire       out2_r,
	input wire       cts_in,
	input wire       dsr_in,
	input wire       ri_in,
	input wire       dcd_in
);
	reg [7:0] lcr_r, mcr_r, ier_r, dll_r;
	reg [8:0] prev_r;
	reg [3:0] quiet_r;
	wire [8:0] modem_now = {cts_in, dsr_in, ri_in, dcd_in, mcr_r[4:0]};
	// quiet count guards level reads against modem inputs or modem control bits changing before the read
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			{lcr_r, mcr_r, ier_r, dll_r} <= {24'h00_0000, 8'h0c};
			prev_r <= 9'h000;
			quiet_r <= 4'h0;
		end else begin
			prev_r <= modem_now;
			if (prev_r != modem_now) quiet_r <= 4'h0;
			else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
			if (port_wr) case (port_addr)
				`OFF_LCR: lcr_r <= port_wdata;
				`OFF_MCR: mcr_r <= port_wdata & 8'h1f;
				`OFF_IER: if (!lcr_r[7]) ier_r <= port_wdata & 8'h0f;
				`OFF_DATA: if (lcr_r[7]) dll_r <= port_wdata;
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence rd(a);
		port_rd && port_addr == a;
	endsequence
	sequence loop_held;
		mcr_r[4] && $past(mcr_r[4]);
	endsequence
	lcr_read_a: assert property (rd(`OFF_LCR) |=> port_rdata_r == lcr_r)
		else $error("line control readback wrong");
	mcr_read_a: assert property (rd(`OFF_MCR) |=> port_rdata_r == mcr_r)
		else $error("modem control readback wrong");
	ier_read_a: assert property (rd(`OFF_IER) && !lcr_r[7] |=> port_rdata_r == ier_r)
		else $error("interrupt enable readback wrong");
	div_read_a: assert property (rd(`OFF_DATA) && lcr_r[7] |=> port_rdata_r == dll_r)
		else $error("divisor low readback wrong");
	lsr_bits_a: assert property (rd(`OFF_LSR) |=> !port_rdata_r[7] &&
		(!port_rdata_r[6] || port_rdata_r[5])) else $error("line status idle bits wrong");
	break_hold_a: assert property (lcr_r[6] && $past(lcr_r[6]) && !mcr_r[4] |-> !tx_out_r)
		else $error("break not held on transmit line");
	modem_outs_a: assert property (!mcr_r[4] && mcr_r == $past(mcr_r) |->
		{out2_r, out1_r, rts_r, dtr_r} == mcr_r[3:0]) else $error("modem outputs wrong");
	loop_quiet_a: assert property (loop_held |-> {out2_r, out1_r, rts_r, dtr_r} == 4'h0)
		else $error("modem outputs active in loopback");
	msr_level_a: assert property (rd(`OFF_MSR) && quiet_r > 4'h4 |=> port_rdata_r[7:4] ==
		(mcr_r[4] ? {mcr_r[3:2], mcr_r[0], mcr_r[1]} : {dcd_in, ri_in, dsr_in, cts_in}))
		else $error("modem status levels wrong");
	rdata_hold_a: assert property (!port_rd |=> $stable(port_rdata_r))
		else $error("read data changed without a read");
	intr_off_a: assert property (ier_r == 8'h00 && $past(ier_r) == 8'h00 |-> !intr_r)
		else $error("interrupt raised while all disabled");
endmodule
bind async_serial_port_controller port_checker chk (.*);
`default_nettype wire

/* tb/serial_terminal.sv */
// Purpose: terminal model on the serial side of the port controller
// Assumes: line idles at mark, bit length set by the bench
// Notes: only frames the bench asks for are sent or taken
`timescale 1ns/1ns
`default_nettype none
module serial_terminal (
	input  wire clock,
	input  wire tx_line,
	output reg  rx_line,
	output reg  cts,
	output reg  dsr,
	output reg  ri,
	output reg  dcd
);
	integer bit_clks = 16;
	integer i, j;
	initial begin
		rx_line = 1'b1;
		{cts, dsr, ri, dcd} = 4'h0;
	end
	task hold(input b);
		begin
			rx_line = b;
			repeat (bit_clks) @(posedge clock);
			#10;
		end
	endtask
	// start low, lsb first, stop level chosen so framing faults can be made
	task send(input [7:0] d, input integer n, input stop);
		begin
			@(posedge clock) #10 hold(1'b0);
			for (i = 0; i < n; i = i + 1) hold(d[i]);
			hold(stop);
			rx_line = 1'b1;
		end
	endtask
	// samples mid-bit; bit n holds parity or first stop
	task get(input integer n, output [8:0] f);
		begin
			f = 9'h000;
			@(negedge tx_line);
			repeat (bit_clks / 2) @(posedge clock);
			for (j = 0; j <= n; j = j + 1) begin
				repeat (bit_clks) @(posedge clock);
				f[j] = tx_line;
			end
			// past a parity bit the stop bit still runs; wait until the line is idle
			repeat (2 * bit_clks) @(posedge clock);
		end
	endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench of the serial port controller
// Assumes: divisor one or two so frames stay short
// Notes: terminal model stands on the serial side
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_consts.vh"
module tb_top;
	reg        clock, rst_b, port_rd, port_wr;
	reg  [9:0] port_addr;
	reg  [7:0] port_wdata, v, p, q, lc;
	reg  [8:0] f;
	wire [7:0] port_rdata_r;
	wire       intr_r, tx_out_r, rx_in, dtr_r, rts_r, out1_r, out2_r;
	wire       cts_in, dsr_in, ri_in, dcd_in;
	integer    seed = 32'h0000_d1d7;
	integer    error_cnt = 0, checked = 0, cyc = 0, i, k;
	async_serial_port_controller DUT (.*);
	serial_terminal term (.clock(clock), .tx_line(tx_out_r), .rx_line(rx_in), .cts(cts_in),
		.dsr(dsr_in), .ri(ri_in), .dcd(dcd_in));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			error_cnt = error_cnt + 1;
			end_of_test;
		end
	end
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", checked, error_cnt);
			if (error_cnt == 0 && checked > 0) $display("Simulation passed");
			else $display("Simulation failed");
			$finish;
		end
	endtask
	task wr(input [9:0] a, input [7:0] d);
		begin
			@(posedge clock) #10 {port_addr, port_wdata, port_wr} = {a, d, 1'b1};
			@(posedge clock) #10 port_wr = 1'b0;
		end
	endtask
	task rd(input [9:0] a, output [7:0] d);
		begin
			@(posedge clock) #10 {port_addr, port_rd} = {a, 1'b1};
			@(posedge clock) #10 port_rd = 1'b0;
			d = port_rdata_r;
		end
	endtask
	task chk(input [8*8-1:0] name, input [8:0] exp, input [8:0] got);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				$display("MISMATCH %0s exp %h got %h", name, exp, got);
				error_cnt = error_cnt + 1;
			end
		end
	endtask
	task rchk(input [8*8-1:0] name, input [9:0] a, input [7:0] m, input [7:0] e);
		begin
			rd(a, v);
			chk(name, {1'b0, e}, {1'b0, v & m});
		end
	endtask
	task wait_intr;
		begin
			for (k = 0; k < 600 && intr_r !== 1'b1; k = k + 1) @(posedge clock);
			#10;
		end
	endtask
	// frame as the wire should carry it, parity or stop just above the data
	function [8:0] expf(input [7:0] d, input [7:0] c);
		reg [7:0] m;
		begin
			m = d & (8'hff >> (3 - c[1:0]));
			expf = {1'b0, m} | ((c[3] ? ~^{c[4], m} : 1'b1) << (c[1:0] + 5));
		end
	endfunction
	initial begin
		{rst_b, port_rd, port_wr, port_addr, port_wdata} = 20'h0_0000;
		repeat (3) @(posedge clock);
		#10 rst_b = 1'b1;
		rchk("lcr", `OFF_LCR, 8'hff, 8'h00);
		rchk("mcr", `OFF_MCR, 8'hff, 8'h00);
		rchk("iir", `OFF_IIR, 8'hff, `IIR_NONE);
		rchk("lsr", `OFF_LSR, 8'hff, 8'h60);
		wr(`OFF_LCR, 8'h80);
		rchk("div", `OFF_DATA, 8'hff, 8'h0c);
		$display("test reset done");
		for (i = 0; i < 4; i = i + 1) begin
			{p, q} = $random(seed);
			wr(`OFF_LCR, p & 8'h7f);
			wr(`OFF_MCR, q);
			wr(`OFF_IER, q);
			rchk("ier", `OFF_IER, 8'hff, q & 8'h0f);
			wr(`OFF_LCR, 8'h80);
			wr(`OFF_DATA, p);
			wr(`OFF_IER, q);
			rchk("dlh", `OFF_IER, 8'hff, q);
		end
		wr(`OFF_DATA, 8'h01);
		wr(`OFF_IER, 8'h00);
		wr(`OFF_MCR, 8'h00);
		$display("test registers done");
		for (i = 0; i < 7; i = i + 1) begin
			lc = (i < 4) ? i : ((i == 4) ? 8'h1b : ((i == 5) ? 8'h0b : 8'h83));
			if (i == 6) begin
				wr(`OFF_LCR, 8'h80);
				wr(`OFF_DATA, 8'h02); // divisor two doubles the bit time
			end
			term.bit_clks = (i == 6) ? 32 : 16;
			wr(`OFF_LCR, lc & 8'h7f);
			p = $random(seed);
			fork
				term.get((lc[1:0] + 5) + 0, f);
				wr(`OFF_DATA, p);
			join
			chk("tx frame", expf(p, lc), f);
			rchk("lsr", `OFF_LSR, 8'h60, 8'h60);
		end
		wr(`OFF_LCR, 8'h80);
		wr(`OFF_DATA, 8'h01);
		term.bit_clks = 16;
		wr(`OFF_LCR, 8'h43);
		@(posedge clock) #10 chk("break", 9'h000, {8'h00, tx_out_r});
		wr(`OFF_LCR, 8'h03);
		$display("test transmit done");
		wr(`OFF_IER, 8'h07);
		rchk("iir", `OFF_IIR, 8'hff, `IIR_TX_HOLDING_EMPTY);
		p = $random(seed) | 8'h01;
		term.send(p, 8, 1'b1);
		wait_intr;
		rchk("iir", `OFF_IIR, 8'hff, `IIR_RXDATA);
		rchk("lsr", `OFF_LSR, 8'h01, 8'h01);
		rchk("rx", `OFF_DATA, 8'hff, p);
		rchk("iir", `OFF_IIR, 8'hff, `IIR_NONE);
		term.send(p, 8, 1'b0);
		wait_intr;
		rchk("iir", `OFF_IIR, 8'hff, `IIR_LINE);
		rchk("lsr", `OFF_LSR, 8'h1f, 8'h09);
		rchk("iir", `OFF_IIR, 8'hff, `IIR_RXDATA);
		rchk("rx", `OFF_DATA, 8'hff, p);
		term.send(p, 8, 1'b1);
		term.send(~p, 8, 1'b1);
		wait_intr;
		rchk("lsr", `OFF_LSR, 8'h03, 8'h03);
		rd(`OFF_DATA, v);
		$display("test receive done");
		wr(`OFF_IER, 8'h08);
		rd(`OFF_MSR, v);
		term.cts = 1'b1;
		wait_intr;
		rchk("iir", `OFF_IIR, 8'hff, `IIR_MODEM);
		rchk("msr", `OFF_MSR, 8'hff, 8'h11);
		rchk("msr", `OFF_MSR, 8'hff, 8'h10);
		term.ri = 1'b1;
		repeat (6) @(posedge clock);
		#10 term.ri = 1'b0;
		wait_intr;
		rchk("msr", `OFF_MSR, 8'hff, 8'h14);
		{term.dsr, term.dcd} = 2'b11;
		wait_intr;
		rchk("msr", `OFF_MSR, 8'hff, 8'hba);
		$display("test modem done");
		wr(`OFF_IER, 8'h00);
		wr(`OFF_MCR, 8'h1d);
		repeat (8) @(posedge clock);
		rchk("loop msr", `OFF_MSR, 8'hf0, 8'he0);
		p = $random(seed);
		wr(`OFF_DATA, p);
		v = 8'h00;
		for (k = 0; k < 600 && v[0] !== 1'b1; k = k + 1) rd(`OFF_LSR, v);
		rchk("loop rx", `OFF_DATA, 8'hff, p);
		$display("test loopback done");
		end_of_test;
	end
endmodule
`default_nettype wire
